// ---- design/qccc_pkg.sv ----
/*
  Constants shared by the quad counter compare control block.
  Assumes a 32-bit Wishbone classic bus and a 100 MHz clock.
*/
package qccc_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_OPLO   = 8'h04;
  localparam logic [7:0] ADDR_OPHI   = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0c;
  localparam logic [7:0] ADDR_RESHI  = 8'h10;
  localparam logic [7:0] ADDR_ERR    = 8'h14;
  localparam logic [7:0] ADDR_TBL    = 8'h18;
  localparam logic [7:0] ADDR_MIRROR = 8'h20;
  localparam logic [7:0] ADDR_CFG    = 8'h30;
  localparam logic [7:0] ADDR_SCAN   = 8'h34;
  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_CODE_LSB = 4;
  localparam int CMD_PORT_LSB = 8;
  localparam int CMD_INT_BIT  = 20;
  localparam int CMD_BUSY_BIT = 21;
  localparam logic [3:0] OP_MODE = 4'h1;
  localparam logic [3:0] OP_TBL  = 4'h2;
  localparam logic [3:0] OP_READ = 4'h3;
  localparam logic [11:0] CODE_0 = 12'h000;
  localparam logic [11:0] CODE_1 = 12'h001;
  localparam logic [11:0] CODE_2 = 12'h002;
  localparam logic [11:0] CODE_3 = 12'h003;
  localparam logic [11:0] PORT_S1 = 12'h100;
  localparam logic [11:0] PORT_S2 = 12'h000;
  // ----------------------------------------------------------------
  // Status word bits
  // ----------------------------------------------------------------
  localparam int ST_RUN  = 12;
  localparam int ST_CMP  = 13;
  localparam int ST_OVF  = 14;
  localparam int ST_LIM  = 15;
  localparam int ST_EXT  = 8;
  // ----------------------------------------------------------------
  // Count ranges
  // ----------------------------------------------------------------
  localparam logic [31:0] LIN_BCD_MIN = 32'hf838_8608;
  localparam logic [31:0] LIN_BCD_MAX = 32'h0838_8607;
  localparam logic [31:0] LIN_HEX_MIN = 32'hf800_0000;
  localparam logic [31:0] LIN_HEX_MAX = 32'h07ff_ffff;
  localparam logic [31:0] RING_MIN    = 32'h0000_0000;
  localparam logic [2:0]  CFG_SLOT2 = 3'h1;
  localparam logic [2:0]  CFG_HEX   = 3'h2;
  localparam logic [2:0]  CFG_RING  = 3'h4;
  localparam logic [31:0] FAULT_PORT  = 32'h0000_0001;
  localparam logic [31:0] FAULT_METH  = 32'h0000_0002;
  localparam logic [31:0] FAULT_TBL   = 32'h0000_0004;
  localparam logic [31:0] FAULT_BUSY  = 32'h0000_0008;
  localparam logic [31:0] BUS_ZERO    = 32'h0000_0000;
  // Comparison methods
  typedef enum logic [1:0] {
    QCCC_M_NONE   = 2'b00,
    QCCC_M_TARGET = 2'b01,
    QCCC_M_RANGE  = 2'b10
  } qccc_method_type;
endpackage

// ---- design/qccc_top.sv ----
/*
  Command, status and table comparison logic for four counter channels.
  Assumes a Wishbone classic master; count pulses arrive as pins.
*/
// Added by the designer: the address map and the Wishbone register port.
// Functional notes
// - Status bit 12 shows counter running.
// - Status bit 13 shows comparison active.
// - Status bit 14 sets on overflow or underflow.
// - Status bit 15 sets on limit setting error.
// - Target match detected counting up or down.
// - Count starts at 0; no pattern until comparison starts.
// - Table stays valid until reset or new registration.
// - Fault when registering other method while comparing.
// - Fault when port does not support the function or code.
// - Fault and refusal on table overrun or invalid setting.
// - Fault on interrupt command while main command busy.
// - Pattern output only on first time condition holds.
// - Mirror words refresh once per scan; reads are live.
// - Earliest table entry wins when several match.
// - Mode code 000 starts, 001 stops comparison.
// - Mode code 002 loads count from two operand words.
// - Ports 101-104 slot 1, 001-004 slot 2 address channels.
// - Linear count range per BCD or hex format.
// - Ring count range from 0 to format maximum.
// - Read code 000 gives count, 001 gives status word.
// - Status bits 0-7 internal, 8-11 external pattern.
// - External outputs OR external bits of all channels.
`timescale 1ns/1ps
module qccc_top #(
  parameter int NCH = 4,
  parameter int NENT = 8
) (
  // System
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Count pulse pins
  input  wire logic [NCH-1:0]    cnt_up_i,
  input  wire logic [NCH-1:0]    cnt_dn_i,
  // Scan cycle strobe from controller logic
  input  wire logic              scan_i,
  // Outputs
  output logic      [3:0]        ext_out_o,
  output logic                   fault_flag_o
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] present_count_r [NCH];
  logic [31:0] lo_r [NCH][NENT];
  logic [31:0] hi_r [NCH][NENT];
  logic [11:0] pat_r [NCH][NENT];
  logic [NENT-1:0] hit_r [NCH];
  logic [NENT-1:0] ent_en_r [NCH];
  qccc_pkg::qccc_method_type meth_r [NCH];
  logic [NCH-1:0] cmp_r, ovf_r, lim_r;
  logic [11:0]    pat_out_r [NCH];
  logic [15:0]    mirror_r [NCH];
  logic [31:0] cmd_r, oplo_r, ophi_r, res_r, reshi_r, fault_r, tbl_r;
  logic [2:0]  cfg_r;
  logic        ack_r;
  logic [2:0]  up_s [NCH], dn_s [NCH];
  logic        go;
  logic [1:0]  ch;
  logic        port_ok;
  logic [3:0]  op;
  logic [11:0] code, port;
  logic [31:0] newcnt;
  logic        main_busy;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] cmax(input logic [2:0] c);
    cmax = c[2] ? (c[1] ? qccc_pkg::LIN_HEX_MAX : qccc_pkg::LIN_BCD_MAX)
                : (c[1] ? qccc_pkg::LIN_HEX_MAX : qccc_pkg::LIN_BCD_MAX);
  endfunction
  function automatic logic [31:0] cmin(input logic [2:0] c);
    cmin = c[2] ? qccc_pkg::RING_MIN
                : (c[1] ? qccc_pkg::LIN_HEX_MIN : qccc_pkg::LIN_BCD_MIN);
  endfunction
  // In BCD, F in the top digit means negative and the rest is the magnitude; hex is two's complement
  function automatic logic signed [32:0] sval(input logic [31:0] v,
                                              input logic [2:0] c);
    logic [31:0] m;
    logic signed [32:0] r;
    m = {4'h0, v[27:0]};
    r = $signed({1'b0, m});
    if (!c[1] && v[31:28] == 4'hf)
      r = -r;
    else if (c[1])
      r = $signed({v[31], v});
    sval = r;
  endfunction
  // Port code to channel; valid flag in bit 2
  function automatic logic [2:0] pdec(input logic [11:0] p,
                                      input logic [2:0] c);
    logic [11:0] b;
    b = (c == qccc_pkg::CFG_SLOT2) || c[0] ? qccc_pkg::PORT_S2
                                           : qccc_pkg::PORT_S1;
    if (p > b && p <= b + 12'h004)
      pdec = {1'b1, 2'(p - b - 12'h001)};
    else
      pdec = 3'h0;
  endfunction
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign go   = cyc_i && stb_i && !ack_r;
  assign op   = cmd_r[qccc_pkg::CMD_OP_LSB +: 4];
  assign code = {8'h00, cmd_r[qccc_pkg::CMD_CODE_LSB +: 4]};
  assign port = cmd_r[qccc_pkg::CMD_PORT_LSB +: 12];
  assign {port_ok, ch} = pdec(port, cfg_r);
  assign newcnt = {ophi_r[15:0], oplo_r[15:0]};
  assign main_busy = cmd_r[qccc_pkg::CMD_BUSY_BIT];
  logic exec;
  assign exec = go && we_i && adr_i == qccc_pkg::ADDR_CMD && sel_i[0];
  logic [31:0] cmdw;
  assign cmdw = dat_i;
  logic [3:0]  w_op;
  logic [11:0] w_code, w_port;
  logic [2:0]  w_pd;
  assign w_op   = cmdw[qccc_pkg::CMD_OP_LSB +: 4];
  assign w_code = {8'h00, cmdw[qccc_pkg::CMD_CODE_LSB +: 4]};
  assign w_port = cmdw[qccc_pkg::CMD_PORT_LSB +: 12];
  assign w_pd   = pdec(w_port, cfg_r);
  logic w_int_clash;
  assign w_int_clash = cmdw[qccc_pkg::CMD_INT_BIT] && main_busy;
  logic w_bad_port;
  always_comb begin
    w_bad_port = !w_pd[2];
    case (w_op)
      qccc_pkg::OP_MODE: if (w_code > qccc_pkg::CODE_2) w_bad_port = 1'b1;
      qccc_pkg::OP_TBL:  if (w_code > qccc_pkg::CODE_3) w_bad_port = 1'b1;
      qccc_pkg::OP_READ: if (w_code > qccc_pkg::CODE_1) w_bad_port = 1'b1;
      default:           w_bad_port = 1'b1;
    endcase
  end
  // Table registration checks
  qccc_pkg::qccc_method_type w_meth;
  assign w_meth = w_code[0] ? qccc_pkg::QCCC_M_RANGE
                            : qccc_pkg::QCCC_M_TARGET;
  logic w_meth_clash, w_tbl_bad;
  assign w_meth_clash = cmp_r[w_pd[1:0]] && meth_r[w_pd[1:0]] != w_meth
                        && meth_r[w_pd[1:0]] != qccc_pkg::QCCC_M_NONE;
  always_comb begin
    w_tbl_bad = tbl_r[7:0] == 8'h00 || tbl_r[31:8] != 24'h0;
    for (int e = 0; e < NENT; e++)
      if (tbl_r[e] && w_meth == qccc_pkg::QCCC_M_RANGE
          && sval(lo_r[w_pd[1:0]][e], cfg_r)
             > sval(hi_r[w_pd[1:0]][e], cfg_r))
        w_tbl_bad = 1'b1;
  end
  logic w_ok;
  assign w_ok = exec && !w_bad_port && !w_int_clash;
  // ----------------------------------------------------------------
  // Bus registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_r <= 1'b0;
    else       ack_r <= go;
  end
  assign ack_o = ack_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_r <= qccc_pkg::BUS_ZERO;
      oplo_r <= qccc_pkg::BUS_ZERO;
      ophi_r <= qccc_pkg::BUS_ZERO;
      tbl_r <= qccc_pkg::BUS_ZERO;
      cfg_r <= 3'h0;
    end else if (go && we_i) begin
      case (adr_i)
        qccc_pkg::ADDR_CMD:  cmd_r  <= dat_i;
        qccc_pkg::ADDR_OPLO: oplo_r <= dat_i;
        qccc_pkg::ADDR_OPHI: ophi_r <= dat_i;
        qccc_pkg::ADDR_TBL:  tbl_r  <= dat_i;
        qccc_pkg::ADDR_CFG:  cfg_r  <= dat_i[2:0];
        default: ;
      endcase
    end
  end
  // Fault word, set wins over the write-one clear
  logic [31:0] fset;
  always_comb begin
    fset = qccc_pkg::BUS_ZERO;
    if (exec) begin
      if (w_bad_port) fset = fset | qccc_pkg::FAULT_PORT;
      if (w_int_clash) fset = fset | qccc_pkg::FAULT_BUSY;
      if (w_ok && w_op == qccc_pkg::OP_TBL) begin
        if (w_meth_clash) fset = fset | qccc_pkg::FAULT_METH;
        if (w_tbl_bad)    fset = fset | qccc_pkg::FAULT_TBL;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) fault_r <= qccc_pkg::BUS_ZERO;
    else if (go && we_i && adr_i == qccc_pkg::ADDR_ERR)
      fault_r <= (fault_r & ~dat_i) | fset;
    else
      fault_r <= fault_r | fset;
  end
  assign fault_flag_o = |fault_r;
  // ----------------------------------------------------------------
  // Count pins, three-stage synchronisers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          up_s[g] <= 3'h0;
          dn_s[g] <= 3'h0;
        end else begin
          up_s[g] <= {up_s[g][1:0], cnt_up_i[g]};
          dn_s[g] <= {dn_s[g][1:0], cnt_dn_i[g]};
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // Per-channel counting and comparison
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic up_p, dn_p, sel;
      logic signed [32:0] cur;
      logic [NENT-1:0] cond;
      // Edge seen while stage 2 has the new level and stage 3 still the old one
      assign up_p = up_s[g][1] && !up_s[g][2];
      assign dn_p = dn_s[g][1] && !dn_s[g][2];
      assign sel = w_ok && w_pd[1:0] == 2'(g);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          present_count_r[g] <= qccc_pkg::RING_MIN;
          ovf_r[g] <= 1'b0;
        end else if (sel && w_op == qccc_pkg::OP_MODE
                     && w_code == qccc_pkg::CODE_2) begin
          present_count_r[g] <= newcnt;
        end else if (up_p) begin
          if (present_count_r[g] == cmax(cfg_r)) begin
            present_count_r[g] <= cfg_r[2] ? qccc_pkg::RING_MIN
                                           : present_count_r[g];
            ovf_r[g] <= ovf_r[g] | !cfg_r[2];
          end else
            present_count_r[g] <= present_count_r[g] + 32'h1;
        end else if (dn_p) begin
          if (present_count_r[g] == cmin(cfg_r)) begin
            present_count_r[g] <= cfg_r[2] ? cmax(cfg_r)
                                           : present_count_r[g];
            ovf_r[g] <= ovf_r[g] | !cfg_r[2];
          end else
            present_count_r[g] <= present_count_r[g] - 32'h1;
        end
      end
      // Table registration, start and stop
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meth_r[g] <= qccc_pkg::QCCC_M_NONE;
          cmp_r[g] <= 1'b0;
          lim_r[g] <= 1'b0;
          ent_en_r[g] <= '0;
        end else if (sel && w_op == qccc_pkg::OP_TBL) begin
          if (w_tbl_bad) lim_r[g] <= 1'b1;
          if (!w_meth_clash && !w_tbl_bad) begin
            meth_r[g] <= w_meth;
            ent_en_r[g] <= tbl_r[NENT-1:0];
            cmp_r[g] <= !w_code[1];
          end
        end else if (sel && w_op == qccc_pkg::OP_MODE) begin
          if (w_code == qccc_pkg::CODE_0
              && meth_r[g] != qccc_pkg::QCCC_M_NONE)
            cmp_r[g] <= 1'b1;
          else if (w_code == qccc_pkg::CODE_1)
            cmp_r[g] <= 1'b0;
        end
      end
      assign cur = sval(present_count_r[g], cfg_r);
      always_comb begin
        for (int e = 0; e < NENT; e++)
          cond[e] = ent_en_r[g][e] &&
            (meth_r[g] == qccc_pkg::QCCC_M_TARGET
              ? cur == sval(lo_r[g][e], cfg_r)
              : cur >= sval(lo_r[g][e], cfg_r)
                && cur <= sval(hi_r[g][e], cfg_r));
      end
      always_ff @(posedge clk_i) begin
        if (rst_i || !cmp_r[g]) begin
          hit_r[g] <= '0;
          pat_out_r[g] <= 12'h000;
        end else begin
          hit_r[g] <= cond;
          for (int e = NENT - 1; e >= 0; e--)
            if (cond[e] && !hit_r[g][e])
              pat_out_r[g] <= pat_r[g][e];
        end
      end
    end
  endgenerate
  // Table entry words written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++)
        for (int e = 0; e < NENT; e++) begin
          lo_r[c][e] <= qccc_pkg::BUS_ZERO;
          hi_r[c][e] <= qccc_pkg::BUS_ZERO;
          pat_r[c][e] <= 12'h000;
        end
    end else if (go && we_i && adr_i[7:6] == 2'b01) begin
      case (adr_i[1:0])
        2'b00: lo_r[oplo_r[9:8]][oplo_r[2:0]] <= dat_i;
        2'b01: hi_r[oplo_r[9:8]][oplo_r[2:0]] <= dat_i;
        default: pat_r[oplo_r[9:8]][oplo_r[2:0]] <= dat_i[11:0];
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Status words, mirror and reads
  // ----------------------------------------------------------------
  function automatic logic [15:0] stw(input int c);
    logic run;
    run = 1'b1;
    stw = {lim_r[c], ovf_r[c], cmp_r[c], run, pat_out_r[c]};
  endfunction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) mirror_r[c] <= 16'h0000;
    end else if (scan_i) begin
      for (int c = 0; c < NCH; c++) mirror_r[c] <= stw(c);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_r <= qccc_pkg::BUS_ZERO;
      reshi_r <= qccc_pkg::BUS_ZERO;
    end else if (w_ok && w_op == qccc_pkg::OP_READ) begin
      if (w_code == qccc_pkg::CODE_0) begin
        res_r <= {16'h0, present_count_r[w_pd[1:0]][15:0]};
        reshi_r <= {16'h0, present_count_r[w_pd[1:0]][31:16]};
      end else
        res_r <= {16'h0, stw(w_pd[1:0])};
    end
  end
  always_comb begin
    ext_out_o = 4'h0;
    for (int c = 0; c < NCH; c++)
      ext_out_o = ext_out_o | pat_out_r[c][11:8];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) dat_o <= qccc_pkg::BUS_ZERO;
    else if (go) begin
      case (adr_i)
        qccc_pkg::ADDR_CMD:    dat_o <= cmd_r;
        qccc_pkg::ADDR_RESULT: dat_o <= res_r;
        qccc_pkg::ADDR_RESHI:  dat_o <= reshi_r;
        qccc_pkg::ADDR_ERR:    dat_o <= fault_r;
        qccc_pkg::ADDR_TBL:    dat_o <= tbl_r;
        qccc_pkg::ADDR_CFG:    dat_o <= {29'h0, cfg_r};
        qccc_pkg::ADDR_MIRROR: dat_o <= {16'h0, mirror_r[0]};
        default:               dat_o <= qccc_pkg::BUS_ZERO;
      endcase
    end
  end
endmodule

// ---- tb/qccc_cpu_model.sv ----
/*
  Controller CPU model: a Wishbone classic master issuing commands.
  Assumes the bench calls its tasks; one clock.
*/
`timescale 1ns/1ps
module qccc_cpu_model (
  // Clock
  input  wire logic        clk_i,
  // Wishbone master
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hf;
    dat_o = 32'h0000_0000;
  end
  function automatic logic [11:0] port_of(input int ch);
    return qccc_pkg::PORT_S1 + 12'(ch + 1);
  endfunction
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= wd;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    rdat = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~wd;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [3:0] code,
                     input logic [11:0] port, input logic [1:0] ctx);
    logic [31:0] junk;
    bus(1'b1, qccc_pkg::ADDR_CMD, {10'h000, ctx, port, code, op}, junk);
  endtask
  task automatic mode(input int ch, input logic [3:0] code,
                      input logic [31:0] cnt);
    logic [31:0] junk;
    logic        ld;
    ld = (code == 4'h2);
    bus(1'b1, qccc_pkg::ADDR_OPLO, ld ? {16'h0, cnt[15:0]} : 32'h0, junk);
    bus(1'b1, qccc_pkg::ADDR_OPHI, ld ? {16'h0, cnt[31:16]} : 32'h0, junk);
    cmd(qccc_pkg::OP_MODE, code, port_of(ch), 2'b00);
  endtask
  task automatic rdv(input int ch, input logic [3:0] code,
                     output logic [31:0] v);
    logic [31:0] lo;
    logic [31:0] hi;
    cmd(qccc_pkg::OP_READ, code, port_of(ch), 2'b00);
    bus(1'b0, qccc_pkg::ADDR_RESULT, 32'h0, lo);
    bus(1'b0, qccc_pkg::ADDR_RESHI, 32'h0, hi);
    v = {hi[15:0], lo[15:0]};
  endtask
  task automatic reg_table(input int ch, input logic [3:0] code,
                           input logic [31:0] tgt, input logic [11:0] pat);
    logic [31:0] junk;
    bus(1'b1, qccc_pkg::ADDR_OPLO, {22'h0, 2'(ch), 8'h00}, junk);
    bus(1'b1, 8'h40, tgt, junk);
    bus(1'b1, 8'h41, 32'h0, junk);
    bus(1'b1, 8'h42, {20'h0, pat}, junk);
    bus(1'b1, qccc_pkg::ADDR_TBL, 32'h1, junk);
    cmd(qccc_pkg::OP_TBL, code, port_of(ch), 2'b00);
  endtask
endmodule

// ---- tb/qccc_top_sva.sv ----
/*
  Concurrent checks on the ports of qccc_top.
  Assumes it is bound from the test top; one clock domain.
*/
`timescale 1ns/1ps
module qccc_top_sva #(
  parameter int NCH  = 4,
  parameter int NENT = 8
) (
  // System
  input wire logic            clk_i,
  input wire logic            rst_i,
  // Wishbone
  input wire logic            cyc_i,
  input wire logic            stb_i,
  input wire logic            we_i,
  input wire logic [7:0]      adr_i,
  input wire logic [3:0]      sel_i,
  input wire logic [31:0]     dat_i,
  input wire logic [31:0]     dat_o,
  input wire logic            ack_o,
  // Pins
  input wire logic [NCH-1:0]  cnt_up_i,
  input wire logic [NCH-1:0]  cnt_dn_i,
  input wire logic            scan_i,
  input wire logic [3:0]      ext_out_o,
  input wire logic            fault_flag_o
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic       take;
  logic       cmd_wr;
  logic       clr_wr;
  logic       bad_cmd;
  logic       busy_r;
  logic [7:0] since_cmd_r;
  logic [7:0] since_clr_r;
  assign take    = cyc_i & stb_i & ~ack_o & we_i;
  assign cmd_wr  = take & (adr_i == qccc_pkg::ADDR_CMD);
  assign clr_wr  = take & (adr_i == qccc_pkg::ADDR_ERR);
  assign bad_cmd = cmd_wr & (dat_i[3:0] inside {qccc_pkg::OP_MODE,
                   qccc_pkg::OP_TBL, qccc_pkg::OP_READ})
                 & ((dat_i[19:8] > 12'h104) | (dat_i[20] & busy_r)
                 | ((dat_i[3:0] == qccc_pkg::OP_MODE)
                 & (dat_i[7:4] == 4'h3)));
  always_ff @(posedge clk_i) begin
    since_cmd_r <= (rst_i | cmd_wr) ? 8'h00
                 : since_cmd_r + {7'h00, since_cmd_r != 8'hff};
  end
  always_ff @(posedge clk_i) begin
    since_clr_r <= (rst_i | clr_wr) ? 8'h00
                 : since_clr_r + {7'h00, since_clr_r != 8'hff};
  end
  always_ff @(posedge clk_i) begin
    busy_r <= rst_i ? 1'b0 : cmd_wr ? dat_i[21] : busy_r;
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_read_holds: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
    else $error("read data changed without request");
  a_reset_quiet: assert property ($fell(rst_i) |->
    !ack_o && ext_out_o == 4'h0 && !fault_flag_o)
    else $error("outputs not idle after reset");
  a_fault_seen: assert property (bad_cmd |-> ##[1:6] fault_flag_o)
    else $error("illegal command raised no fault");
  a_fault_cause: assert property ($rose(fault_flag_o) |->
    since_cmd_r <= 8'h06)
    else $error("fault without a command");
  a_fault_clear: assert property ($fell(fault_flag_o) |->
    since_clr_r <= 8'h06)
    else $error("fault dropped without clear");
  cover property (bad_cmd);
  cover property ($fell(fault_flag_o));
  cover property (ext_out_o == 4'h7);
endmodule

// ---- tb/qccc_top_test.sv ----
/*
  Self-checking bench for qccc_top with a controller CPU model.
  Assumes default configuration: slot 1, BCD, linear counting.
*/
`timescale 1ns/1ps
module qccc_top_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, scan, fault;
  logic [7:0]  adr;
  logic [3:0]  sel, cnt_up, cnt_dn, ext_out;
  logic [31:0] dat_w, dat_r;
  int          err_count = 0;
  int          n_tests = 0;
  always #5 clk_i = ~clk_i;
  qccc_top i_qccc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w),
    .dat_o(dat_r), .ack_o(ack), .cnt_up_i(cnt_up), .cnt_dn_i(cnt_dn),
    .scan_i(scan), .ext_out_o(ext_out), .fault_flag_o(fault));
  qccc_cpu_model i_qccc_cpu_model (.clk_i(clk_i), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dat_w),
    .dat_i(dat_r), .ack_i(ack));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time,
               what, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] rnd_bcd();
    logic [31:0] r;
    r = 32'($urandom % 8);
    for (int k = 0; k < 6; k++) r = {r[27:0], 4'($urandom % 10)};
    return r;
  endfunction
  task automatic pulse(input int ch, input logic up);
    @(posedge clk_i);
    if (up) cnt_up[ch] <= 1'b1; else cnt_dn[ch] <= 1'b1;
    repeat (2) @(posedge clk_i);
    cnt_up <= 4'h0;
    cnt_dn <= 4'h0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic status(input int ch, output logic [15:0] s);
    logic [31:0] v;
    i_qccc_cpu_model.rdv(ch, 4'h1, v);
    s = v[15:0];
  endtask
  task automatic expect_fault(input logic [31:0] code);
    logic [31:0] v;
    i_qccc_cpu_model.bus(1'b0, qccc_pkg::ADDR_ERR, 32'h0, v);
    check(v, code, "fault word");
    check(32'(fault), 32'h1, "fault flag set");
    i_qccc_cpu_model.bus(1'b1, qccc_pkg::ADDR_ERR, code, v);
    i_qccc_cpu_model.bus(1'b0, qccc_pkg::ADDR_ERR, 32'h0, v);
    check(v, 32'h0, "fault word cleared");
    check(32'(fault), 32'h0, "fault flag cleared");
  endtask
  initial begin
    logic [31:0] v, got;
    logic [15:0] s;
    void'($urandom(32'h928a27d0));
    {cnt_up, cnt_dn, scan} = 9'h000;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      i_qccc_cpu_model.rdv(c, 4'h0, got);
      check(got, 32'h0, "count after reset");
    end
    check(32'(ext_out), 32'h0, "pattern before compare");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? qccc_pkg::LIN_BCD_MIN
        : (i == 1) ? qccc_pkg::LIN_BCD_MAX : rnd_bcd();
      i_qccc_cpu_model.mode(i % 4, 4'h2, v);
      i_qccc_cpu_model.rdv(i % 4, 4'h0, got);
      check(got, v, "loaded count");
    end
    i_qccc_cpu_model.mode(0, 4'h2, 32'h0);
    i_qccc_cpu_model.reg_table(0, 4'h2, 32'h3, 12'h3a5);
    status(0, s);
    check(32'(s[13]), 32'h0, "compare idle");
    i_qccc_cpu_model.mode(0, 4'h0, 32'h0);
    status(0, s);
    check(32'(s[13]), 32'h1, "compare started");
    repeat (3) pulse(0, 1'b1);
    check(32'(ext_out), 32'h3, "up match outputs");
    status(0, s);
    check(32'(s[11:0]), 32'h3a5, "status pattern");
    i_qccc_cpu_model.bus(1'b0, qccc_pkg::ADDR_MIRROR, 32'h0, got);
    check(got, 32'h0, "mirror before scan");
    @(posedge clk_i);
    scan <= 1'b1;
    @(posedge clk_i);
    scan <= 1'b0;
    i_qccc_cpu_model.bus(1'b0, qccc_pkg::ADDR_MIRROR, 32'h0, got);
    check(32'(got[11:0]), 32'h3a5, "mirror after scan");
    i_qccc_cpu_model.mode(1, 4'h2, 32'h4);
    i_qccc_cpu_model.reg_table(1, 4'h0, 32'h2, 12'h4c0);
    repeat (2) pulse(1, 1'b0);
    check(32'(ext_out), 32'h7, "down match ored");
    i_qccc_cpu_model.mode(0, 4'h1, 32'h0);
    status(0, s);
    check(32'(s[13]), 32'h0, "compare stopped");
    i_qccc_cpu_model.reg_table(1, 4'h1, 32'h0, 12'h001);
    expect_fault(qccc_pkg::FAULT_METH);
    i_qccc_cpu_model.reg_table(2, 4'h3, 32'h0000_00ab, 12'h001);
    expect_fault(qccc_pkg::FAULT_TBL);
    i_qccc_cpu_model.cmd(qccc_pkg::OP_MODE, 4'h1, 12'h105, 2'b00);
    expect_fault(qccc_pkg::FAULT_PORT);
    i_qccc_cpu_model.cmd(qccc_pkg::OP_MODE, 4'h3, 12'h101, 2'b00);
    expect_fault(qccc_pkg::FAULT_PORT);
    i_qccc_cpu_model.cmd(qccc_pkg::OP_READ, 4'h1, 12'h101, 2'b10);
    i_qccc_cpu_model.cmd(qccc_pkg::OP_READ, 4'h0, 12'h101, 2'b01);
    expect_fault(qccc_pkg::FAULT_BUSY);
    i_qccc_cpu_model.mode(3, 4'h2, qccc_pkg::LIN_BCD_MAX);
    pulse(3, 1'b1);
    status(3, s);
    check(32'(s[14]), 32'h1, "overflow flag");
    status(0, s);
    check(32'(s[14]), 32'h0, "no overflow");
    i_qccc_cpu_model.rdv(3, 4'h0, got);
    check(got, qccc_pkg::LIN_BCD_MAX, "count held at top");
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end
endmodule
bind qccc_top qccc_top_sva #(.NCH(NCH), .NENT(NENT)) i_qccc_top_sva (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .cnt_up_i(cnt_up_i),
  .cnt_dn_i(cnt_dn_i), .scan_i(scan_i), .ext_out_o(ext_out_o),
  .fault_flag_o(fault_flag_o));
